/* include/ude_pkg.sv */
package ude_pkg;
	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] A_FLAG0 = 8'h00;
	localparam logic [7:0] A_FLAG1 = 8'h04;
	localparam logic [7:0] A_FLAG2 = 8'h08;
	localparam logic [7:0] A_ENB = 8'h0c;
	localparam logic [7:0] A_TRIG = 8'h10;
	localparam logic [7:0] A_SIZE1 = 8'h14;
	localparam logic [7:0] A_SIZE4 = 8'h18;
	localparam logic [7:0] A_STALL = 8'h1c;
	localparam logic [7:0] A_ASC = 8'h20;
	localparam logic [7:0] A_RSM = 8'h24;
	localparam logic [7:0] A_INFO = 8'h28;
	// Data port of endpoint e sits at 8'h40 + 4*e, e = 1..6
	localparam logic [2:0] DATA_HI = 3'h2;
	// event_flag_reg_0 fields
	localparam int F0_VBF = 0;
	localparam int F0_VMON = 1;
	localparam int F0_SRF = 2;
	localparam int F0_SUSP = 3;
	// event_flag_reg_1 and event_enable_reg_2 fields
	localparam int F1_FULL1 = 0;
	localparam int F1_FULL4 = 1;
	localparam int F1_TR2 = 2;
	localparam int F1_TR5 = 3;
	localparam int F1_EMP2 = 4;
	localparam int F1_EMP5 = 5;
	// event_flag_reg_2 fields
	localparam int F2_TS3 = 4;
	localparam int F2_TS6 = 5;
	// Stall register: set bits at e, clear bits at e + STL_CLR
	localparam int STL_CLR = 8;
	localparam int NUM_EP = 7;
	localparam int NUM_TRIG = 6;
	localparam logic [2:0] INFO_LAST = 3'h4;
	localparam logic [2:0] EP_NONE = 3'h7;
	localparam logic [2:0] EP_BO1 = 3'h1;
	localparam logic [2:0] EP_BI2 = 3'h2;
	localparam logic [2:0] EP_II3 = 3'h3;
	localparam logic [2:0] EP_BO4 = 3'h4;
	localparam logic [2:0] EP_BI5 = 3'h5;
	localparam logic [2:0] EP_II6 = 3'h6;
	localparam logic [6:0] MAX_BULK_DEF = 7'h40;
	localparam logic [6:0] MAX_INTR_DEF = 7'h10;

	typedef enum logic [1:0] {PID_OUT, PID_IN, PID_SETUP} ude_pid_e;
	typedef enum logic [1:0] {RSP_NAK, RSP_ACK, RSP_STALL, RSP_DATA} ude_resp_e;

	typedef struct packed {
		logic tok_v;
		ude_pid_e tok_pid;
		logic [3:0] tok_ep;
		logic rx_v;
		logic [7:0] rx_data;
		logic rx_end;
		logic rx_ok;
		logic tx_rd;
		logic hs_ack;
		logic feat_v;
		logic feat_set;
		logic [3:0] feat_ep;
		logic suspend;
	} ude_sie_in_s;

	typedef struct packed {
		logic resp_v;
		ude_resp_e resp;
		logic [6:0] tx_len;
		logic [7:0] tx_data;
		logic resume_req;
	} ude_sie_out_s;
endpackage : ude_pkg

/* verilog/ude_engine.sv */
`timescale 1ns/1ps
module ude_engine import ude_pkg::*; #(
	parameter logic [6:0] MAX_BULK = MAX_BULK_DEF,
	parameter logic [6:0] MAX_INTR = MAX_INTR_DEF
) (
	input wire logic clk_i, // 40 MHz clock
	input wire logic rst_i, // Synchronous reset, high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic vbus_i, // Bus power pin, asynchronous
	input wire ude_sie_in_s sie_i, // Events from serial engine
	output ude_sie_out_s sie_o // Answers to serial engine
);
	typedef struct packed {
		logic ack;
		logic [15:0] rdat;
		logic [6:0] stall;
		logic [6:0] asc;
		logic [6:0] armed;
		logic [6:0][6:0] cnt;
		logic [6:0][6:0] ptr;
		logic [5:0] enb;
		logic [1:0] tr;
		logic [1:0] ts;
		logic vbf;
		logic srf;
		logic vs1;
		logic vs2;
		logic vs3;
		logic susp_q;
		logic [2:0] info_ep;
		logic [2:0] info_byte;
		logic locked;
		logic [6:0][3:0] hnum;
		logic [2:0] out_ep;
		logic out_go;
		logic [2:0] in_ep;
		logic in_pend;
		ude_sie_out_s usb;
	} ude_state_s;

	ude_state_s s;
	ude_state_s n;
	logic [7:0] mem [0:511];
	logic acc;
	logic wr;
	logic [2:0] dsel;
	logic dok;
	logic [7:0] d8;
	logic [15:0] rv;
	logic [2:0] hep;
	logic [2:0] fep;
	logic [2:0] te;
	logic cw_en;
	logic [8:0] cw_a;
	logic rw_en;
	logic [8:0] rw_a;

	////////////////////////////////////////////////////////////////
	function automatic logic is_out(input logic [2:0] e);
		return (e == EP_BO1) || (e == EP_BO4);
	endfunction : is_out

	function automatic logic is_bin(input logic [2:0] e);
		return (e == EP_BI2) || (e == EP_BI5);
	endfunction : is_bin

	function automatic logic is_iin(input logic [2:0] e);
		return (e == EP_II3) || (e == EP_II6);
	endfunction : is_iin

	function automatic logic [6:0] ep_max(input logic [2:0] e);
		return is_iin(e) ? MAX_INTR : MAX_BULK;
	endfunction : ep_max

	// Host endpoint number to local index; identity until info is locked
	function automatic logic [2:0] map_ep(input logic [3:0] h, input logic [6:0][3:0] tab,
		input logic lk);
		logic [2:0] r;
		r = EP_NONE;
		if (!lk) begin
			if (h < 4'(NUM_EP)) begin
				r = h[2:0];
			end
		end else begin
			// Lowest index wins, so zeroed unused endpoints never shadow endpoint 0
			for (int i = NUM_EP - 1; i >= 0; i--) begin
				if (tab[i] == h) begin
					r = 3'(i);
				end
			end
		end
		return r;
	endfunction : map_ep

	function automatic logic [2:0] trig_ep(input int i);
		case (i)
			0: return EP_BO1;
			1: return EP_BO4;
			2: return EP_BI2;
			3: return EP_BI5;
			4: return EP_II3;
			default: return EP_II6;
		endcase
	endfunction : trig_ep

	////////////////////////////////////////////////////////////////
	always_comb begin
		n = s;
		acc = wb_cyc_i & wb_stb_i & ~s.ack;
		wr = acc & wb_we_i & wb_sel_i[0];
		d8 = wb_dat_i[7:0];
		dsel = wb_adr_i[4:2];
		dok = (wb_adr_i[7:5] == DATA_HI) && (wb_adr_i[1:0] == 2'h0) && (dsel != 3'h0)
			&& (dsel != EP_NONE);
		hep = map_ep(sie_i.tok_ep, s.hnum, s.locked);
		fep = map_ep(sie_i.feat_ep, s.hnum, s.locked);
		te = 3'h0;
		cw_en = 1'b0;
		cw_a = {dsel, s.cnt[dsel][5:0]};
		rw_en = 1'b0;
		rw_a = {s.out_ep, s.cnt[s.out_ep][5:0]};
		rv = 16'h0;
		n.ack = acc;
		n.usb.resp_v = 1'b0;
		n.vs1 = vbus_i;
		n.vs2 = s.vs1;
		n.vs3 = s.vs2;
		n.susp_q = sie_i.suspend;

		// Read mux; full and empty bits in flag 1 only show when enabled
		unique case (wb_adr_i)
			A_FLAG0: begin
				rv[F0_VBF] = s.vbf;
				rv[F0_VMON] = s.vs3;
				rv[F0_SRF] = s.srf;
				rv[F0_SUSP] = s.susp_q;
			end
			A_FLAG1: begin
				rv[F1_FULL1] = s.armed[EP_BO1] & s.enb[F1_FULL1];
				rv[F1_FULL4] = s.armed[EP_BO4] & s.enb[F1_FULL4];
				rv[F1_TR2] = s.tr[0];
				rv[F1_TR5] = s.tr[1];
				rv[F1_EMP2] = ~s.armed[EP_BI2] & s.enb[F1_EMP2];
				rv[F1_EMP5] = ~s.armed[EP_BI5] & s.enb[F1_EMP5];
			end
			A_FLAG2: begin
				rv[F2_TS3] = s.ts[0];
				rv[F2_TS6] = s.ts[1];
			end
			A_ENB: rv[5:0] = s.enb;
			A_SIZE1: rv[6:0] = s.cnt[EP_BO1];
			A_SIZE4: rv[6:0] = s.cnt[EP_BO4];
			A_STALL: rv[6:0] = s.stall;
			A_ASC: rv[6:0] = s.asc;
			A_RSM: rv[0] = s.usb.resume_req;
			A_INFO: rv[6:0] = {s.locked, s.info_ep, s.info_byte};
			default: begin
				if (dok && is_out(dsel)) begin
					rv[7:0] = mem[{dsel, s.ptr[dsel][5:0]}];
				end
			end
		endcase
		if (acc) begin
			n.rdat = rv;
		end

		// Reading an armed OUT data port pops one byte
		if (acc && !wb_we_i && dok && is_out(dsel) && s.armed[dsel]) begin
			n.ptr[dsel] = 7'(s.ptr[dsel] + 7'h1);
		end

		if (wr) begin
			unique case (wb_adr_i)
				A_FLAG0: begin
					n.vbf = s.vbf & d8[F0_VBF];
					n.srf = s.srf & d8[F0_SRF];
				end
				A_FLAG1: begin
					n.tr[0] = s.tr[0] & d8[F1_TR2];
					n.tr[1] = s.tr[1] & d8[F1_TR5];
				end
				A_FLAG2: begin
					n.ts[0] = s.ts[0] & d8[F2_TS3];
					n.ts[1] = s.ts[1] & d8[F2_TS6];
				end
				A_ENB: n.enb = d8[5:0];
				A_TRIG: begin
					for (int i = 0; i < NUM_TRIG; i++) begin
						te = trig_ep(i);
						if (d8[i] && is_out(te)) begin
							n.armed[te] = 1'b0;
							n.cnt[te] = 7'h0;
							n.ptr[te] = 7'h0;
						end else if (d8[i] && !s.armed[te]) begin
							// An empty buffer arms a zero-length packet
							n.armed[te] = 1'b1;
						end
					end
				end
				A_STALL: begin
					n.stall = s.stall | d8[6:0];
					if (wb_sel_i[1]) begin
						n.stall = n.stall & ~wb_dat_i[STL_CLR +: NUM_EP];
					end
				end
				A_ASC: n.asc = d8[6:0];
				A_RSM: n.usb.resume_req = d8[0];
				A_INFO: begin
					if (!s.locked) begin
						n.info_byte = 3'(s.info_byte + 3'h1);
						if (s.info_byte == INFO_LAST) begin
							// Last byte of each group is the host-visible number
							n.hnum[s.info_ep] = d8[3:0];
							n.info_byte = 3'h0;
							n.info_ep = 3'(s.info_ep + 3'h1);
							n.locked = (s.info_ep == 3'(NUM_EP - 1));
						end
					end
				end
				default: begin
					// IN data writes; bytes past the endpoint maximum are dropped
					if (dok && !is_out(dsel) && !s.armed[dsel]
						&& (s.cnt[dsel] < ep_max(dsel))) begin
						cw_en = 1'b1;
						n.cnt[dsel] = 7'(s.cnt[dsel] + 7'h1);
					end
				end
			endcase
		end

		////////////////////////////////////////////////////////////////
		// Link events come after software so that a link update beats a register write
		if (sie_i.tok_v && hep != EP_NONE) begin
			unique case (sie_i.tok_pid)
				PID_SETUP: begin
					n.stall[0] = 1'b0;
					n.out_go = 1'b0;
				end
				PID_IN: begin
					if (s.stall[hep]) begin
						n.usb.resp_v = 1'b1;
						n.usb.resp = RSP_STALL;
						n.stall[hep] = ~s.asc[hep] & n.stall[hep];
					end else if (!is_out(hep) && hep != 3'h0) begin
						n.usb.resp_v = 1'b1;
						if (s.armed[hep]) begin
							// Retried on every IN token until the host acknowledges
							n.usb.resp = RSP_DATA;
							n.usb.tx_len = s.cnt[hep];
							n.ptr[hep] = 7'h0;
							n.in_ep = hep;
							n.in_pend = 1'b1;
						end else begin
							n.usb.resp = RSP_NAK;
						end
						if (hep == EP_BI2 && s.enb[F1_TR2]) begin
							n.tr[0] = 1'b1;
						end
						if (hep == EP_BI5 && s.enb[F1_TR5]) begin
							n.tr[1] = 1'b1;
						end
					end
				end
				PID_OUT: begin
					n.out_ep = hep;
					n.out_go = 1'b1;
					// A stray OUT token to an IN endpoint must not wipe its queued bytes
					if (is_out(hep) && !s.armed[hep]) begin
						n.cnt[hep] = 7'h0;
					end
				end
				default: begin
					n.out_go = 1'b0;
				end
			endcase
		end

		rw_en = sie_i.rx_v && s.out_go && is_out(s.out_ep) && !s.stall[s.out_ep]
			&& !s.armed[s.out_ep] && (s.cnt[s.out_ep] < ep_max(s.out_ep));
		if (rw_en) begin
			n.cnt[s.out_ep] = 7'(s.cnt[s.out_ep] + 7'h1);
		end

		if (sie_i.rx_end && s.out_go) begin
			n.out_go = 1'b0;
			if (s.stall[s.out_ep]) begin
				n.usb.resp_v = 1'b1;
				n.usb.resp = RSP_STALL;
				n.stall[s.out_ep] = ~s.asc[s.out_ep] & n.stall[s.out_ep];
			end else if (is_out(s.out_ep) && s.armed[s.out_ep]) begin
				n.usb.resp_v = 1'b1;
				n.usb.resp = RSP_NAK;
			end else if (is_out(s.out_ep) && sie_i.rx_ok) begin
				n.usb.resp_v = 1'b1;
				n.usb.resp = RSP_ACK;
				n.armed[s.out_ep] = 1'b1;
				n.ptr[s.out_ep] = 7'h0;
			end else if (is_out(s.out_ep)) begin
				// Damaged packet: drop it silently, host will retry
				n.cnt[s.out_ep] = 7'h0;
			end
		end

		if (sie_i.tx_rd && s.in_pend) begin
			n.usb.tx_data = mem[{s.in_ep, s.ptr[s.in_ep][5:0]}];
			n.ptr[s.in_ep] = 7'(s.ptr[s.in_ep] + 7'h1);
		end

		if (sie_i.hs_ack && s.in_pend) begin
			n.in_pend = 1'b0;
			n.armed[s.in_ep] = 1'b0;
			n.cnt[s.in_ep] = 7'h0;
			if (s.in_ep == EP_II3) begin
				n.ts[0] = 1'b1;
			end
			if (s.in_ep == EP_II6) begin
				n.ts[1] = 1'b1;
			end
		end

		if (sie_i.feat_v && fep != EP_NONE) begin
			n.stall[fep] = sie_i.feat_set;
		end

		if (sie_i.suspend != s.susp_q) begin
			n.srf = 1'b1;
		end

		if (s.vs2 != s.vs3) begin
			n.vbf = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Two write ports never collide: software fills IN buffers, the link OUT ones
	always_ff @(posedge clk_i) begin
		if (cw_en) begin
			mem[cw_a] <= d8;
		end
		if (rw_en) begin
			mem[rw_a] <= sie_i.rx_data;
		end
	end

	assign wb_dat_o = {16'h0, s.rdat};
	assign wb_ack_o = s.ack;
	assign sie_o = s.usb;
endmodule : ude_engine

/* verif/ude_engine_asserts.sv */
`timescale 1ns/1ps
module ude_engine_asserts import ude_pkg::*; #(
	parameter logic [6:0] MAX_BULK = MAX_BULK_DEF
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset, high
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [7:0] wb_adr_i, // Address
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Acknowledge
	input wire ude_sie_in_s sie_i, // Link events
	input wire ude_sie_out_s sie_o // Link answers
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	sequence wb_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence wb_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	ack_once_a: assert property (wb_req |=> wb_ans)
		else $error("ack is not one pulse after the request");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	unmapped_zero_a: assert property (wb_req ##0 (!wb_we_i && wb_adr_i == 8'h30)
		|=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	resp_cause_a: assert property (sie_o.resp_v |-> $past(sie_i.tok_v || sie_i.rx_end))
		else $error("answer without token or packet end");
	resp_pulse_a: assert property (sie_o.resp_v |=> !sie_o.resp_v)
		else $error("answer longer than one cycle");
	len_bound_a: assert property (sie_o.resp_v && sie_o.resp == RSP_DATA
		|-> sie_o.tx_len <= MAX_BULK)
		else $error("packet length above maximum");
	txd_hold_a: assert property (!sie_i.tx_rd |=> $stable(sie_o.tx_data))
		else $error("transmit byte moved without fetch");
	resume_cause_a: assert property ($rose(sie_o.resume_req)
		|-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == A_RSM))
		else $error("resume request without a register write");
	stray_tok_a: assert property (sie_i.tok_v && sie_i.tok_ep > 4'h6 |=> !sie_o.resp_v)
		else $error("answer to an unmapped endpoint");
endmodule : ude_engine_asserts

/* verif/ude_host_model.sv */
`timescale 1ns/1ps
module ude_host_model import ude_pkg::*; (
	input wire logic clk_i, // Device clock
	output ude_sie_in_s sie_o // Link events to the engine
);
	int gap = 0;
	initial sie_o = '0;
	// Idle cycles before each event model a slow host
	task automatic pulse(input ude_sie_in_s s);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		s.suspend = sie_o.suspend;
		sie_o <= s;
		@(posedge clk_i);
		s = '{tok_pid: PID_OUT, suspend: s.suspend, default: '0};
		// Released tok_ep and rx_data flip so a stale value never reads as fresh
		s.tok_ep = ~sie_o.tok_ep;
		s.rx_data = ~sie_o.rx_data;
		sie_o <= s;
	endtask : pulse
	////////////////////////////////////////
	task automatic tok(input ude_pid_e p, input logic [3:0] e);
		pulse('{tok_v: 1'b1, tok_pid: p, tok_ep: e, default: '0});
	endtask : tok
	task automatic rxb(input logic [7:0] d);
		pulse('{tok_pid: PID_OUT, rx_v: 1'b1, rx_data: d, default: '0});
	endtask : rxb
	task automatic fin(input logic ok);
		pulse('{tok_pid: PID_OUT, rx_end: 1'b1, rx_ok: ok, default: '0});
	endtask : fin
	task automatic rd;
		pulse('{tok_pid: PID_OUT, tx_rd: 1'b1, default: '0});
	endtask : rd
	task automatic hs;
		pulse('{tok_pid: PID_OUT, hs_ack: 1'b1, default: '0});
	endtask : hs
	task automatic feat(input logic st, input logic [3:0] e);
		pulse('{tok_pid: PID_OUT, feat_v: 1'b1, feat_set: st, feat_ep: e, default: '0});
	endtask : feat
	task automatic susp(input logic v);
		@(posedge clk_i);
		sie_o.suspend <= v;
	endtask : susp
endmodule : ude_host_model

/* verif/ude_engine_tb.sv */
`timescale 1ns/1ps
module ude_engine_tb import ude_pkg::*; ;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic vbus = 1'b0;
	logic [31:0] q;
	ude_sie_in_s sie_host;
	ude_sie_out_s sie_dev;
	int failures = 0;
	int n_compared = 0;
	always #12.5 clk_i = ~clk_i;
	ude_engine u_ude_engine (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .vbus_i(vbus), .sie_i(sie_host), .sie_o(sie_dev));
	ude_host_model u_host (.clk_i(clk_i), .sie_o(sie_host));
	////////////////////////////////////////
	task automatic complete_run;
		$display("compared %0d, failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t: seen %h, expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= s;
		wb_dat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (wb_ack !== 1'b1) begin
			failures++;
			complete_run();
		end
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'h1);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'h1);
		chk(q, e);
	endtask : rdc
	// Answer stands one cycle only, so look right after the causing edge
	task automatic rs(input ude_resp_e r, input logic [6:0] l);
		#1;
		chk(sie_dev.resp_v, 1'b1);
		chk(sie_dev.resp, r);
		if (r == RSP_DATA) begin
			chk(sie_dev.tx_len, l);
		end
	endtask : rs
	task automatic fx(input logic [7:0] b, input int n);
		for (int k = 0; k < n; k++) begin
			u_host.rd();
			#1;
			chk(sie_dev.tx_data, 8'(b + k));
		end
		u_host.hs();
	endtask : fx
	////////////////////////////////////////
	initial begin
		int ep;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(A_ENB, 0);
		rdc(A_STALL, 0);
		rdc(8'h30, 0);
		wr(A_ENB, 8'h3f);
		rdc(A_FLAG1, 8'h30);
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			ep = i ? 5 : 2;
			for (int k = 0; k < 3; k++) begin
				wr(8'(8'h40 + 4 * ep), 8'ha0 + k);
			end
			wr(A_TRIG, 1 << (2 + i));
			rdc(A_FLAG1, 8'h30 & ~(1 << (4 + i)));
			u_host.tok(PID_IN, 4'(ep));
			rs(RSP_DATA, 7'h03);
			rdc(A_FLAG1, (8'h30 & ~(1 << (4 + i))) | (1 << (2 + i)));
			fx(8'ha0, 3);
			wr(A_FLAG1, ~(1 << (2 + i)));
			rdc(A_FLAG1, 8'h30);
		end
		wr(A_ENB, 8'h3b);
		wr(A_TRIG, 8'h04);
		u_host.tok(PID_IN, 4'h2);
		rs(RSP_DATA, 7'h00);
		u_host.hs();
		wr(A_ENB, 8'h2b);
		rdc(A_FLAG1, 8'h20);
		wr(A_ENB, 8'h3f);
		$display("test bulk in done");
		u_host.gap = 2;
		for (int i = 0; i < 2; i++) begin
			ep = i ? 4 : 1;
			u_host.tok(PID_OUT, 4'(ep));
			u_host.rxb(8'h50);
			u_host.rxb(8'h51);
			u_host.fin(1'b1);
			rs(RSP_ACK, 7'h00);
			rdc(A_FLAG1, 8'h30 | (1 << i));
			rdc(i ? A_SIZE4 : A_SIZE1, 2);
			rdc(8'(8'h40 + 4 * ep), 8'h50);
			rdc(8'(8'h40 + 4 * ep), 8'h51);
			wr(A_TRIG, 1 << i);
			rdc(A_FLAG1, 8'h30);
		end
		u_host.gap = 0;
		$display("test bulk out done");
		for (int i = 0; i < 2; i++) begin
			ep = i ? 6 : 3;
			for (int k = 0; k < 17; k++) begin
				wr(8'(8'h40 + 4 * ep), k);
			end
			wr(A_TRIG, 1 << (4 + i));
			u_host.tok(PID_IN, 4'(ep));
			rs(RSP_DATA, 7'h10);
			fx(8'h00, 16);
		end
		rdc(A_FLAG2, 8'h30);
		wr(A_FLAG2, 8'hef);
		rdc(A_FLAG2, 8'h20);
		wr(A_FLAG2, 8'hdf);
		rdc(A_FLAG2, 8'h00);
		$display("test interrupt in done");
		wr(A_STALL, 8'h04);
		u_host.tok(PID_IN, 4'h2);
		rs(RSP_STALL, 7'h00);
		wb(1'b1, A_STALL, 32'h0400, 4'h3);
		rdc(A_STALL, 0);
		wr(A_ASC, 8'h04);
		wr(A_STALL, 8'h04);
		u_host.tok(PID_IN, 4'h2);
		rs(RSP_STALL, 7'h00);
		rdc(A_STALL, 0);
		wr(A_STALL, 8'h01);
		u_host.tok(PID_SETUP, 4'h0);
		rdc(A_STALL, 0);
		u_host.feat(1'b1, 4'h5);
		rdc(A_STALL, 8'h20);
		u_host.feat(1'b0, 4'h5);
		rdc(A_STALL, 0);
		wr(A_STALL, 8'h02);
		u_host.tok(PID_OUT, 4'h1);
		u_host.fin(1'b1);
		rs(RSP_STALL, 7'h00);
		rdc(A_FLAG1, 8'h30);
		wb(1'b1, A_STALL, 32'h0200, 4'h3);
		rdc(A_STALL, 0);
		$display("test stall done");
		u_host.susp(1'b1);
		rdc(A_FLAG0, 8'h0c);
		wr(A_FLAG0, 8'hfb);
		rdc(A_FLAG0, 8'h08);
		u_host.susp(1'b0);
		rdc(A_FLAG0, 8'h04);
		wr(A_FLAG0, 8'hfb);
		vbus <= 1'b1;
		repeat (4) @(posedge clk_i);
		rdc(A_FLAG0, 8'h03);
		wr(A_FLAG0, 8'hfe);
		vbus <= 1'b0;
		repeat (4) @(posedge clk_i);
		rdc(A_FLAG0, 8'h01);
		wr(A_FLAG0, 8'hfe);
		rdc(A_FLAG0, 8'h00);
		$display("test bus events done");
		for (int e = 0; e < 7; e++) begin
			for (int b = 0; b < 5; b++) begin
				wr(A_INFO, b == 4 ? e : 0);
			end
		end
		// Locked, endpoint counter past the last group, byte index back at 0
		rdc(A_INFO, 8'h78);
		wr(A_INFO, 8'h09);
		rdc(A_INFO, 8'h78);
		u_host.tok(PID_IN, 4'h9);
		#1;
		chk(sie_dev.resp_v, 1'b0);
		wr(A_RSM, 8'h00);
		chk(sie_dev.resume_req, 1'b0);
		$display("test info done");
		complete_run();
	end
endmodule : ude_engine_tb
bind ude_engine ude_engine_asserts #(.MAX_BULK(MAX_BULK)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sie_i(sie_i), .sie_o(sie_o));
